// file: rtcp_top.sv
// real-time counter and periodic interrupt timer with apb registers
//
// Operation
// - counter halts on cpu debug halt unless its debug_run is set
// - calibration register: sign bit 7, magnitude 6:0, reset zero
// - sign zero slows the prescaler, sign one speeds it up
// - magnitude is correction clocks per million counter clock cycles
// - two-bit source field picks one of four clock sources
// - 16-bit counter, period, compare; low byte at base, high at base plus four
// - counter write takes effect two counter clocks later; resets to zero
// - compare value is 16-bit read/write, resets to zero
// - period field 6:3: off, 4 to 32768 cycles doubling, 0xf reserved
// - bit 0 of periodic control enables the periodic timer; reset zero
// - periodic status bit 0 is high while control write synchronises
// - bit 0 of periodic irq enable gates the periodic interrupt
// - periodic flag sets on each periodic event, cleared by writing one
// - periodic timer halts on debug halt unless its debug_run is set
// - wrap flag on counter reaching period, compare flag on match, write one clears
// - interrupt request stays high while flag and enable are both set
// - prescaler divides counter clock by two to the field value
// - resuming from halt with periodic output high gives a new flag edge
`timescale 1ns/1ps
module rtcp_top #(
    parameter int CORR_INTERVAL = rtcp_pkg::CORR_INTERVAL
) (
    input  wire logic                         sys_clk,
    input  wire logic                         reset_n,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [rtcp_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                  pwdata,
    input  wire logic [3:0]                   pstrb,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    input  wire logic                         cpu_halted,
    input  wire logic                         internal_32k_clk,
    input  wire logic                         internal_1k_clk,
    input  wire logic                         crystal_clk,
    input  wire logic                         external_pin_clk,
    output logic                              rtc_irq,
    output logic                              pit_irq,
    output logic                              pit_out
);
    localparam int ACC_W = $clog2(CORR_INTERVAL + 128);
    localparam logic [ACC_W-1:0] CORR_N = ACC_W'(CORR_INTERVAL);

    if (CORR_INTERVAL < 128) begin : g_bad_interval
        $error("correction interval must exceed the largest magnitude");
    end

    // ---------------- apb front end ----------------
    logic [rtcp_pkg::IDX_W-1:0] idx;
    logic                       aligned;
    logic                       setup_ph;
    logic                       wr_en;
    logic [7:0]                 wbyte;

    assign idx      = paddr[rtcp_pkg::PADDR_W-1:2];
    assign aligned  = (paddr[1:0] == 2'h0);
    assign setup_ph = psel & ~penable & ~pready;
    assign wr_en    = psel & penable & pready & pwrite & ~pslverr & pstrb[0];
    assign wbyte    = pwdata[7:0];

    wire hit_ctrl    = wr_en && (idx == rtcp_pkg::IDX_CTRL);
    wire hit_iflag   = wr_en && (idx == rtcp_pkg::IDX_INT_FLAG);
    wire hit_cnt_lo  = wr_en && (idx == rtcp_pkg::IDX_CNT_LO);
    wire hit_cnt_hi  = wr_en && (idx == rtcp_pkg::IDX_CNT_HI);
    wire hit_per_lo  = wr_en && (idx == rtcp_pkg::IDX_PER_LO);
    wire hit_per_hi  = wr_en && (idx == rtcp_pkg::IDX_PER_HI);
    wire hit_cmp_lo  = wr_en && (idx == rtcp_pkg::IDX_CMP_LO);
    wire hit_cmp_hi  = wr_en && (idx == rtcp_pkg::IDX_CMP_HI);
    wire hit_temp    = wr_en && (idx == rtcp_pkg::IDX_TEMP);
    wire hit_pitctl  = wr_en && (idx == rtcp_pkg::IDX_PIT_CTRL);
    wire hit_pitflag = wr_en && (idx == rtcp_pkg::IDX_PIT_FLAG);

    // ---------------- software registers ----------------
    logic                       dbg_run_q;
    logic                       pit_dbg_run_q;
    logic [1:0]                 int_en_q;
    logic                       pit_ien_q;
    rtcp_pkg::rtcp_crystal_error_calibration_type   crystal_error_calibration_q;
    rtcp_pkg::rtcp_clk_src_type clock_source_field_q;
    logic [7:0]                 temp_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dbg_run_q     <= 1'b0;
            pit_dbg_run_q <= 1'b0;
            int_en_q      <= 2'h0;
            pit_ien_q     <= 1'b0;
            crystal_error_calibration_q       <= rtcp_pkg::BYTE_RESET;
            clock_source_field_q      <= rtcp_pkg::internal_32k_source;
        end else if (wr_en) begin
            if (idx == rtcp_pkg::IDX_DEBUG) begin
                dbg_run_q <= wbyte[0];
            end else if (idx == rtcp_pkg::IDX_PIT_DEBUG) begin
                pit_dbg_run_q <= wbyte[0];
            end else if (idx == rtcp_pkg::IDX_INT_EN) begin
                int_en_q <= wbyte[1:0];
            end else if (idx == rtcp_pkg::IDX_PIT_IEN) begin
                pit_ien_q <= wbyte[0];
            end else if (idx == rtcp_pkg::IDX_CRYSTAL_ERROR_CALIBRATION) begin
                crystal_error_calibration_q <= wbyte;
            end else if (idx == rtcp_pkg::IDX_CLOCK_SOURCE_FIELD) begin
                clock_source_field_q <= rtcp_pkg::rtcp_clk_src_type'(wbyte[1:0]);
            end
        end
    end

    // ---------------- counter clock source ----------------
    logic [3:0] src_sync;
    logic       src_prev_q;
    logic       src_level;
    logic       tick;

    rtcp_sync #(
        .WIDTH (4)
    ) u_src_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({external_pin_clk, crystal_clk, internal_1k_clk, internal_32k_clk}),
        .sync_out (src_sync)
    );

    // source select; switching may yield one stray tick
    assign src_level = src_sync[clock_source_field_q];
    assign tick      = src_level & ~src_prev_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_level;
        end
    end

    // ---------------- synchronised writes ----------------
    rtcp_pkg::rtcp_ctrl_type     ctrl_eff;
    rtcp_pkg::rtcp_pit_ctrl_type pit_eff;
    logic [15:0]                 per_eff;
    logic [15:0]                 cmp_eff;
    logic [15:0]                 cnt_wval;
    logic                        cnt_apply;
    logic [3:0]                  busy;
    logic                        pit_busy;

    // busy from bus write until captured
    rtcp_wsync #(
        .WIDTH     (6),
        .RESET_VAL (6'h00)
    ) u_ctrl_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr      (hit_ctrl),
        .wdata   ({wbyte[6:3], wbyte[2], wbyte[0]}),
        .tick    (tick),
        .busy    (busy[rtcp_pkg::BUSY_CTRL_BIT]),
        .apply   (),
        .value   (ctrl_eff)
    );

    // counter load lands two ticks after the write
    rtcp_wsync #(
        .WIDTH     (16),
        .RESET_VAL (rtcp_pkg::CNT_RESET)
    ) u_cnt_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr      (hit_cnt_hi),
        .wdata   ({wbyte, temp_q}),
        .tick    (tick),
        .busy    (busy[rtcp_pkg::BUSY_CNT_BIT]),
        .apply   (cnt_apply),
        .value   (cnt_wval)
    );

    rtcp_wsync #(
        .WIDTH     (16),
        .RESET_VAL (rtcp_pkg::PER_RESET)
    ) u_per_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr      (hit_per_hi),
        .wdata   ({wbyte, temp_q}),
        .tick    (tick),
        .busy    (busy[rtcp_pkg::BUSY_PER_BIT]),
        .apply   (),
        .value   (per_eff)
    );

    rtcp_wsync #(
        .WIDTH     (16),
        .RESET_VAL (rtcp_pkg::CMP_RESET)
    ) u_cmp_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr      (hit_cmp_hi),
        .wdata   ({wbyte, temp_q}),
        .tick    (tick),
        .busy    (busy[rtcp_pkg::BUSY_CMP_BIT]),
        .apply   (),
        .value   (cmp_eff)
    );

    rtcp_wsync #(
        .WIDTH     (5),
        .RESET_VAL (5'h00)
    ) u_pit_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .wr      (hit_pitctl),
        .wdata   ({wbyte[6:3], wbyte[0]}),
        .tick    (tick),
        .busy    (pit_busy),
        .apply   (),
        .value   (pit_eff)
    );

    // ---------------- prescaler with correction ----------------
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_sum;
    logic [15:0]      psc_q;
    logic [15:0]      psc_inc;
    logic [15:0]      psc_sum;
    logic [15:0]      div_val;
    logic             rtc_run;
    logic             corr_due;
    logic             step;

    assign rtc_run  = ctrl_eff.enable & (dbg_run_q | ~cpu_halted);
    assign acc_sum  = acc_q + ACC_W'(crystal_error_calibration_q.magnitude);
    assign corr_due = ctrl_eff.correction_enable && (acc_sum >= CORR_N);
    // slip one clock or add one extra
    assign psc_inc  = !corr_due ? 16'h0001 : (crystal_error_calibration_q.sign ? 16'h0002 : 16'h0000);
    assign psc_sum  = psc_q + psc_inc;
    // divide by two to the prescaler field
    assign div_val  = 16'h0001 << ctrl_eff.prescaler;
    assign step     = rtc_run && tick && (psc_sum >= div_val);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            acc_q <= '0;
            psc_q <= 16'h0000;
        end else if (rtc_run && tick) begin
            acc_q <= corr_due ? acc_sum - CORR_N : (ctrl_eff.correction_enable ? acc_sum : '0);
            psc_q <= step ? psc_sum - div_val : psc_sum;
        end
    end

    // ---------------- counter and flags ----------------
    logic [15:0] cnt_q;
    logic [15:0] cnt_next;
    logic        wrap_evt;
    logic        cmp_evt;
    logic [1:0]  flag_q;
    logic [1:0]  flag_set;
    logic [1:0]  flag_clr;

    assign wrap_evt = step && (cnt_q == per_eff);
    assign cnt_next = wrap_evt ? 16'h0000 : cnt_q + 16'h0001;
    assign cmp_evt  = step && (cnt_next == cmp_eff);
    assign flag_set = {cmp_evt, wrap_evt};
    assign flag_clr = hit_iflag ? wbyte[1:0] : 2'h0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q  <= rtcp_pkg::CNT_RESET;
            flag_q <= 2'h0;
        end else begin
            if (cnt_apply) begin
                cnt_q <= cnt_wval;
            end else if (step) begin
                cnt_q <= cnt_next;
            end
            flag_q <= (flag_q & ~flag_clr) | flag_set;
        end
    end

    // ---------------- periodic interrupt timer ----------------
    logic [15:0] pit_cnt_q;
    logic        pit_active;
    logic        pit_level;
    logic        pit_evt;
    logic        pit_flag_q;

    // enable; off and reserved codes stop it
    // debug halt unless its own debug_run
    assign pit_active = pit_eff.periodic_timer_enable
                        && (pit_eff.period != rtcp_pkg::PIT_PERIOD_OFF)
                        && (pit_eff.period != rtcp_pkg::PIT_PERIOD_RSVD)
                        && (pit_dbg_run_q || !cpu_halted);
    // period code n toggles bit n: 2^(n+1) cycles
    assign pit_level  = pit_active && pit_cnt_q[pit_eff.period];
    // output forced low in halt, so resume gives a new edge
    assign pit_evt    = pit_level && !pit_out;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pit_cnt_q  <= 16'h0000;
            pit_out    <= 1'b0;
            pit_flag_q <= 1'b0;
        end else begin
            if (!pit_eff.periodic_timer_enable) begin
                pit_cnt_q <= 16'h0000;
            end else if (pit_active && tick) begin
                pit_cnt_q <= pit_cnt_q + 16'h0001;
            end
            pit_out    <= pit_level;
            // set on each edge, set wins over clear
            pit_flag_q <= (pit_flag_q & ~(hit_pitflag & wbyte[0])) | pit_evt;
        end
    end

    // request held while flag and enable
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rtc_irq <= 1'b0;
            pit_irq <= 1'b0;
        end else begin
            rtc_irq <= |(flag_q & int_en_q);
            pit_irq <= pit_flag_q & pit_ien_q;
        end
    end

    // ---------------- read path ----------------
    logic [7:0] rd_byte;
    logic       rd_hit;

    // low byte at base, high byte via temp
    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        if (idx == rtcp_pkg::IDX_CTRL) begin
            rd_byte = {1'b0, ctrl_eff.prescaler, ctrl_eff.correction_enable, 1'b0, ctrl_eff.enable};
        end else if (idx == rtcp_pkg::IDX_STATUS) begin
            rd_byte = {4'h0, busy};
        end else if (idx == rtcp_pkg::IDX_INT_EN) begin
            rd_byte = {6'h00, int_en_q};
        end else if (idx == rtcp_pkg::IDX_INT_FLAG) begin
            rd_byte = {6'h00, flag_q};
        end else if (idx == rtcp_pkg::IDX_TEMP || idx == rtcp_pkg::IDX_CNT_HI
                     || idx == rtcp_pkg::IDX_PER_HI || idx == rtcp_pkg::IDX_CMP_HI) begin
            rd_byte = temp_q;
        end else if (idx == rtcp_pkg::IDX_DEBUG) begin
            rd_byte = {7'h00, dbg_run_q};
        end else if (idx == rtcp_pkg::IDX_CRYSTAL_ERROR_CALIBRATION) begin
            rd_byte = crystal_error_calibration_q;
        end else if (idx == rtcp_pkg::IDX_CLOCK_SOURCE_FIELD) begin
            rd_byte = {6'h00, clock_source_field_q};
        end else if (idx == rtcp_pkg::IDX_CNT_LO) begin
            rd_byte = cnt_q[7:0];
        end else if (idx == rtcp_pkg::IDX_PER_LO) begin
            rd_byte = per_eff[7:0];
        end else if (idx == rtcp_pkg::IDX_CMP_LO) begin
            rd_byte = cmp_eff[7:0];
        end else if (idx == rtcp_pkg::IDX_PIT_CTRL) begin
            rd_byte = {1'b0, pit_eff.period, 2'h0, pit_eff.periodic_timer_enable};
        end else if (idx == rtcp_pkg::IDX_PIT_STAT) begin
            rd_byte = {7'h00, pit_busy};
        end else if (idx == rtcp_pkg::IDX_PIT_IEN) begin
            rd_byte = {7'h00, pit_ien_q};
        end else if (idx == rtcp_pkg::IDX_PIT_FLAG) begin
            rd_byte = {7'h00, pit_flag_q};
        end else if (idx == rtcp_pkg::IDX_PIT_DEBUG) begin
            rd_byte = {7'h00, pit_dbg_run_q};
        end else begin
            rd_hit = 1'b0;
        end
    end

    wire rd_setup = setup_ph && !pwrite && aligned;
    wire [15:0] hi_src = (idx == rtcp_pkg::IDX_CNT_LO) ? cnt_q
                       : (idx == rtcp_pkg::IDX_PER_LO) ? per_eff : cmp_eff;
    wire lo_read = rd_setup && (idx == rtcp_pkg::IDX_CNT_LO || idx == rtcp_pkg::IDX_PER_LO
                                || idx == rtcp_pkg::IDX_CMP_LO);

    // temp: snapshot of high byte on low read, staging on low write
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_q <= rtcp_pkg::BYTE_RESET;
        end else if (hit_cnt_lo || hit_per_lo || hit_cmp_lo || hit_temp) begin
            temp_q <= wbyte;
        end else if (lo_read) begin
            temp_q <= hi_src[15:8];
        end
    end

    // zero-wait slave: pready rises in the cycle after setup
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready  <= 1'b1;
            pslverr <= ~(aligned & rd_hit);
            prdata  <= rd_setup ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule

// file: rtcp_pkg.sv
// shared constants and types of the real-time counter and periodic timer
package rtcp_pkg;

    localparam int PADDR_W = 8;
    localparam int IDX_W   = 6;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL      = 6'h00;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 6'h01;
    localparam logic [IDX_W-1:0] IDX_INT_EN    = 6'h02;
    localparam logic [IDX_W-1:0] IDX_INT_FLAG  = 6'h03;
    localparam logic [IDX_W-1:0] IDX_TEMP      = 6'h04;
    localparam logic [IDX_W-1:0] IDX_DEBUG     = 6'h05;
    localparam logic [IDX_W-1:0] IDX_CRYSTAL_ERROR_CALIBRATION     = 6'h06;
    localparam logic [IDX_W-1:0] IDX_CLOCK_SOURCE_FIELD    = 6'h07;
    localparam logic [IDX_W-1:0] IDX_CNT_LO    = 6'h08;
    localparam logic [IDX_W-1:0] IDX_CNT_HI    = 6'h09;
    localparam logic [IDX_W-1:0] IDX_PER_LO    = 6'h0a;
    localparam logic [IDX_W-1:0] IDX_PER_HI    = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_CMP_LO    = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_CMP_HI    = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_PIT_CTRL  = 6'h10;
    localparam logic [IDX_W-1:0] IDX_PIT_STAT  = 6'h11;
    localparam logic [IDX_W-1:0] IDX_PIT_IEN   = 6'h12;
    localparam logic [IDX_W-1:0] IDX_PIT_FLAG  = 6'h13;
    localparam logic [IDX_W-1:0] IDX_PIT_DEBUG = 6'h15;

    // reset values
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET  = 16'h0000;
    localparam logic [15:0] PER_RESET  = 16'hffff;
    localparam logic [15:0] CMP_RESET  = 16'h0000;

    // bit positions
    localparam int FLAG_WRAP_BIT   = 0;
    localparam int FLAG_CMP_BIT    = 1;
    localparam int BUSY_CTRL_BIT   = 0;
    localparam int BUSY_CNT_BIT    = 1;
    localparam int BUSY_PER_BIT    = 2;
    localparam int BUSY_CMP_BIT    = 3;
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_CORR_BIT   = 2;
    localparam int CTRL_PRESC_LSB  = 3;
    localparam int PIT_EN_BIT      = 0;
    localparam int PIT_PERIOD_LSB  = 3;
    localparam int CRYSTAL_ERROR_CALIBRATION_SIGN_BIT  = 7;

    // prescaler and period codes
    localparam logic [3:0] PRESC_DIVIDE_BY_TWO = 4'h1;
    localparam logic [3:0] PRESC_DIVIDE_BY_MAX = 4'hf;
    localparam logic [3:0] PIT_PERIOD_OFF      = 4'h0;
    localparam logic [3:0] PIT_PERIOD_RSVD     = 4'hf;

    // counter-clock ticks from bus write to effect
    localparam int SYNC_TICKS = 2;
    // counter-clock cycles per correction interval
    localparam int CORR_INTERVAL = 1000000;

    typedef enum logic [1:0] {
        internal_32k_source       = 2'b00,
        internal_1k_source        = 2'b01,
        crystal_source            = 2'b10,
        external_clock_pin_source = 2'b11
    } rtcp_clk_src_type;

    typedef struct packed {
        logic [3:0] prescaler;
        logic       correction_enable;
        logic       enable;
    } rtcp_ctrl_type;

    typedef struct packed {
        logic       sign;
        logic [6:0] magnitude;
    } rtcp_crystal_error_calibration_type;

    typedef struct packed {
        logic [3:0] period;
        logic       periodic_timer_enable;
    } rtcp_pit_ctrl_type;

endpackage

// file: rtcp_sync.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
module rtcp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// file: rtcp_wsync.sv
// bus write carried into the counter-clock tick domain with busy flag
`timescale 1ns/1ps
module rtcp_wsync #(
    parameter int             WIDTH     = 16,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             wr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic             tick,
    output logic                  busy,
    output logic                  apply,
    output logic      [WIDTH-1:0] value
);
    logic [WIDTH-1:0] pend_q;
    logic [1:0]       ticks_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_q  <= RESET_VAL;
            value   <= RESET_VAL;
            busy    <= 1'b0;
            apply   <= 1'b0;
            ticks_q <= 2'h0;
        end else if (wr) begin
            // a fresh write restarts the latency count
            pend_q  <= wdata;
            busy    <= 1'b1;
            apply   <= 1'b0;
            ticks_q <= 2'h0;
        end else if (busy && tick) begin
            if (ticks_q == 2'(rtcp_pkg::SYNC_TICKS - 1)) begin
                value <= pend_q;
                busy  <= 1'b0;
                apply <= 1'b1;
            end else begin
                ticks_q <= ticks_q + 2'h1;
                apply   <= 1'b0;
            end
        end else begin
            apply <= 1'b0;
        end
    end
endmodule

// file: rtcp_src_model.sv
// counter clock sources at the far side of the block
`timescale 1ns/1ps
module rtcp_src_model (
    input  wire logic xtal_en,
    output logic      clk_32k,
    output logic      clk_1k,
    output logic      clk_xtal,
    output logic      clk_ext
);
    initial {clk_32k, clk_1k, clk_xtal, clk_ext} = 4'h0;
    // four unrelated sources, all slower than the bus clock
    always #610 clk_32k = !clk_32k;
    always #1950 clk_1k = !clk_1k;
    always #765 clk_ext = !clk_ext;
    // crystal stands still until it is enabled
    always #455 clk_xtal = xtal_en & !clk_xtal;
endmodule

// file: rtcp_top_asserts.sv
// port checker for the counter and periodic timer
`timescale 1ns/1ps
module rtcp_top_chk (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rtc_irq,
    input wire logic        pit_irq
);
    logic wr_q;
    wire  setup = psel & !penable;
    wire  wr_now = psel & pwrite;
    // a write may clear a flag, so irq may fall one cycle later
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            wr_q <= 1'b0;
        else
            wr_q <= wr_now;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_ready_after_setup: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_needs_sel: assert property (!psel |=> !pready)
        else $error("ready without select");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_misaligned_err: assert property (setup && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("misaligned access not refused");
    a_rtc_irq_hold: assert property (rtc_irq && !wr_q && !wr_now |=> rtc_irq)
        else $error("counter irq dropped without write");
    a_pit_irq_hold: assert property (pit_irq && !wr_q && !wr_now |=> pit_irq)
        else $error("periodic irq dropped without write");
    cover property (pslverr);
    cover property ($rose(rtc_irq));
    cover property ($rose(pit_irq));
endmodule
bind rtcp_top rtcp_top_chk rtcp_top_chk_inst (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rtc_irq(rtc_irq), .pit_irq(pit_irq));

// file: tb_real_time_counter_pit_regs.sv
// self-checking bench for the counter and periodic timer
`timescale 1ns/1ps
module tb_real_time_counter_pit_regs;
    logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic        cpu_halted = 1'b0, xtal_en = 1'b0, err;
    logic        pready, pslverr, rtc_irq, pit_irq, pit_out, c32, c1, cx, ce;
    int          num_errors = 0, num_checks = 0;
    always #50 sys_clk = !sys_clk;
    rtcp_src_model rtcp_src_model_inst (.xtal_en(xtal_en), .clk_32k(c32), .clk_1k(c1),
        .clk_xtal(cx), .clk_ext(ce));
    rtcp_top #(.CORR_INTERVAL(200)) rtcp_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_halted(cpu_halted), .internal_32k_clk(c32), .internal_1k_clk(c1),
        .crystal_clk(cx), .external_pin_clk(ce), .rtc_irq(rtc_irq), .pit_irq(pit_irq),
        .pit_out(pit_out));
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h0);
        chk(rd, exp);
    endtask
    // poll a busy register until its four busy bits show their syncs have landed
    task automatic idle(input logic [7:0] a);
        do bus(1'b0, a, 8'h0); while (rd[3:0] !== 4'h0);
    endtask
    task automatic t_reset;
        rdchk(8'h28, 32'hff);
        rdchk(8'h2c, 32'hff);
        rdchk(8'h18, 32'h0);
        rdchk(8'h30, 32'h0);
        rdchk(8'h40, 32'h0);
    endtask
    task automatic t_regs;
        wr(8'h18, 8'h85);
        rdchk(8'h18, 32'h85);
        // crystal runs before it is selected
        xtal_en <= 1'b1;
        for (int s = 3; s >= 0; s--) begin
            wr(8'h1c, s[7:0]);
            rdchk(8'h1c, s);
        end
        wr(8'h30, 8'h35);
        wr(8'h34, 8'h12);
        idle(8'h04);
        rdchk(8'h30, 32'h35);
        rdchk(8'h34, 32'h12);
        bus(1'b0, 8'h3a, 8'h0);
        chk(err, 1'b1);
    endtask
    task automatic t_count;
        wr(8'h18, 8'h00);
        wr(8'h28, 8'h35);
        wr(8'h2c, 8'h12);
        wr(8'h20, 8'h34);
        wr(8'h24, 8'h12);
        bus(1'b0, 8'h04, 8'h0);
        chk(rd[1], 1'b1);
        idle(8'h04);
        rdchk(8'h20, 32'h34);
        rdchk(8'h24, 32'h12);
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h01);
        wait (rtc_irq === 1'b1);
        rdchk(8'h0c, 32'h3);
        wr(8'h0c, 8'h03);
        repeat (2) @(posedge sys_clk);
        chk(rtc_irq, 1'b0);
        wr(8'h00, 8'h0d);
    endtask
    task automatic t_corr(input logic [7:0] cal, input int lo, input int hi);
        wr(8'h18, cal);
        wr(8'h20, 8'h00);
        wr(8'h24, 8'h00);
        repeat (40) @(posedge c32);
        bus(1'b0, 8'h20, 8'h0);
        chk(rd >= lo && rd <= hi, 1'b1);
    endtask
    task automatic t_pit;
        wr(8'h48, 8'h01);
        wr(8'h40, 8'h09);
        bus(1'b0, 8'h44, 8'h0);
        chk(rd[0], 1'b1);
        wait (pit_irq === 1'b1);
        rdchk(8'h4c, 32'h1);
        wr(8'h4c, 8'h01);
        repeat (2) @(posedge sys_clk);
        chk(pit_irq, 1'b0);
        wait (pit_out === 1'b1);
        @(posedge sys_clk);
        cpu_halted <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(pit_out, 1'b0);
        cpu_halted <= 1'b0;
        rdchk(8'h4c, 32'h1);
        wr(8'h54, 8'h01);
        wr(8'h4c, 8'h01);
        cpu_halted <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(pit_irq, 1'b0);
        wait (pit_irq === 1'b1);
        rdchk(8'h4c, 32'h1);
        cpu_halted <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset;
        t_regs;
        t_count;
        t_corr(8'he4, 25, 32);
        t_corr(8'h64, 7, 12);
        t_pit;
        end_sim;
    end
    // hang limit, about 50000 clocks
    initial begin
        #5000000;
        num_errors++;
        end_sim;
    end
endmodule
